// file: hdl/drs_pkg.sv
package drs_pkg;

  // Loop and input counts
  localparam int NUM_LOOPS = 2;
  localparam int NUM_EXT = 4;
  localparam int NUM_SLOTS = 5;
  localparam int PRIO_W = 3;
  localparam int CODE_W = 3;
  localparam int ADDR_W = 8;
  localparam int VAL_W = 16;

  // Register byte addresses
  localparam logic [7:0] ADDR_CTRL0 = 8'h00;
  localparam logic [7:0] ADDR_CTRL1 = 8'h04;
  localparam logic [7:0] ADDR_PRIO0 = 8'h08;
  localparam logic [7:0] ADDR_PRIO1 = 8'h0C;
  localparam logic [7:0] ADDR_VALTIME = 8'h10;
  localparam logic [7:0] ADDR_STAT0 = 8'h14;
  localparam logic [7:0] ADDR_STAT1 = 8'h18;

  // Control register fields
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_PINS_BIT = 2;
  localparam int CTRL_CODE_LSB = 3;
  localparam int CTRL_HITLESS_BIT = 6;
  localparam int CTRL_W = 7;

  // Status register fields
  localparam int STAT_SEL_LSB = 0;
  localparam int STAT_STATE_LSB = 3;
  localparam int STAT_VALID_LSB = 5;

  // Reset values
  localparam logic [6:0] CTRL_RESET = 7'h00;
  localparam logic [14:0] PRIO_RESET = 15'h0000;
  localparam logic [15:0] VALTIME_RESET = 16'h0010;

  // Selection codes shared by register code, status and status pins
  localparam logic [2:0] CODE_LOOP1_VCO = 3'h4; // loop1_vco_loopback, usable by loop 2
  localparam logic [2:0] CODE_LOOP2_VCO = 3'h5; // loop2_vco_loopback, usable by loop 1
  localparam logic [2:0] SLOT_LOOPBACK = 3'h4;
  localparam logic [2:0] PRIO_IGNORE = 3'h0;
  localparam logic [2:0] PRIO_NONE = 3'h7;

  typedef enum logic [1:0] {
    DRS_AUTO_REVERT = 2'b00,
    DRS_AUTO_HOLD = 2'b01,
    DRS_MAN_FALLBACK = 2'b10,
    DRS_MAN_HOLDOVER = 2'b11
  } drs_mode_t;

  typedef enum logic [1:0] {
    DRS_ST_FREERUN = 2'b00,
    DRS_ST_LOCKED = 2'b01,
    DRS_ST_HOLDOVER = 2'b10
  } drs_state_t;

  // Per-loop status carried to pins and registers
  typedef struct packed {
    drs_state_t state;
    logic [2:0] sel;
  } drs_status_t;

  // Per-loop switchover treatment strobes
  typedef struct packed {
    logic phase_cancel;
    logic phase_slew;
    logic smooth_freq;
    logic gap_exempt;
  } drs_switch_t;

endpackage : drs_pkg

// file: hdl/drs_selector.sv
// Our own choices: the register addresses and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// - Auto priority, register or pin manual selection.
// - Four inputs plus other loop's VCO loopback.
// - Priority 0 ignored, 1 best, 6 worst.
// - Equal priority prefers lowest input index.
// - Selected input shown on pins and register.
// - Revertive mode jumps to better valid input.
// - Non-revertive keeps current until it fails.
// - Manual fallback moves to best valid input.
// - No valid fallback: holdover if history, else freerun.
// - Manual holdover mode never falls back.
// - Manual input valid again ends holdover.
// - Register code 0-3 inputs, 4/5 loopbacks.
// - Pin code 0-3 picks external inputs.
// - Hitless enable cancels phase on locked switch.
// - Frequency-locked means common divided rate.
// - Without hitless, step slews at fastlock rate.
// - Unlocked inputs get smooth frequency move.
// - Loop locks to gapped input, average rate.
// - Switch during a gap may exceed hitless.
// - Input valid after flag-free validation time.
// - Switch only between common-rate divided inputs.
module drs_selector #(
  parameter int VAL_W = drs_pkg::VAL_W
) (
  input wire logic clk_sys_i,
  input wire logic rstn_i,
  input wire logic ce_i,
  // Register port
  input wire logic [drs_pkg::ADDR_W-1:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_write_i,
  input wire logic reg_read_i,
  output logic [31:0] reg_rdata_o,
  // Input qualification, per external input and per loop loopback
  input wire logic [drs_pkg::NUM_EXT-1:0] monitor_flag_i,
  input wire logic [drs_pkg::NUM_LOOPS-1:0] loopback_valid_i,
  input wire logic [drs_pkg::NUM_EXT-1:0] input_in_gap_i,
  // Per loop: slot may share the common comparison rate
  input wire logic [drs_pkg::NUM_LOOPS*drs_pkg::NUM_SLOTS-1:0] common_rate_ok_i,
  input wire logic [drs_pkg::NUM_LOOPS-1:0] history_valid_i,
  // Select pins, two per loop, from outside the clock domain
  input wire logic [drs_pkg::NUM_LOOPS*2-1:0] input_select_pins_i,
  // Status pins and switchover strobes
  output drs_pkg::drs_status_t [drs_pkg::NUM_LOOPS-1:0] loop_status_o,
  output drs_pkg::drs_switch_t [drs_pkg::NUM_LOOPS-1:0] switch_o,
  output logic [drs_pkg::NUM_EXT-1:0] input_valid_o
);

  logic [drs_pkg::CTRL_W-1:0] ctrl [drs_pkg::NUM_LOOPS];
  logic [drs_pkg::NUM_SLOTS*drs_pkg::PRIO_W-1:0] prio [drs_pkg::NUM_LOOPS];
  logic [VAL_W-1:0] val_time;
  logic [VAL_W-1:0] val_cnt [drs_pkg::NUM_EXT];
  logic [drs_pkg::NUM_EXT-1:0] ext_valid;
  logic [31:0] next_rdata;

  assign input_valid_o = ext_valid;

  // Shared validation time, written as a whole word
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      val_time <= VAL_W'(drs_pkg::VALTIME_RESET);
    end else if (ce_i && reg_write_i && reg_addr_i == drs_pkg::ADDR_VALTIME) begin
      val_time <= reg_wdata_i[VAL_W-1:0];
    end
  end

  // Validation timers: any flag restarts the count, so an intermittent
  // clock never qualifies while it keeps tripping a monitor
  genvar gi;
  generate
    for (gi = 0; gi < drs_pkg::NUM_EXT; gi++) begin : g_val
      always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
          val_cnt[gi] <= '0;
          ext_valid[gi] <= 1'b0;
        end else if (ce_i) begin
          if (monitor_flag_i[gi]) begin
            val_cnt[gi] <= '0;
            ext_valid[gi] <= 1'b0;
          end else if (val_cnt[gi] >= val_time) begin
            ext_valid[gi] <= 1'b1;
          end else begin
            val_cnt[gi] <= val_cnt[gi] + 1'b1;
          end
        end
      end
    end
  endgenerate

  // Best slot by priority; strict less-than keeps the lowest index on ties
  function automatic logic [3:0] drs_best(
    input logic [drs_pkg::NUM_SLOTS-1:0] ok,
    input logic [drs_pkg::NUM_SLOTS*drs_pkg::PRIO_W-1:0] pr
  );
    logic [2:0] best_pr;
    logic [3:0] best;
    logic [2:0] p;
    best_pr = drs_pkg::PRIO_NONE;
    best = 4'h0;
    for (int s = 0; s < drs_pkg::NUM_SLOTS; s++) begin
      p = pr[s*drs_pkg::PRIO_W +: drs_pkg::PRIO_W];
      if (ok[s] && p != drs_pkg::PRIO_IGNORE && p < best_pr) begin
        best_pr = p;
        best = {1'b1, 3'(s)};
      end
    end
    return best;
  endfunction : drs_best

  drs_pkg::drs_status_t stat [drs_pkg::NUM_LOOPS];

  genvar gl;
  generate
    for (gl = 0; gl < drs_pkg::NUM_LOOPS; gl++) begin : g_loop
      localparam logic [7:0] A_CTRL = (gl == 0) ? drs_pkg::ADDR_CTRL0 : drs_pkg::ADDR_CTRL1;
      localparam logic [7:0] A_PRIO = (gl == 0) ? drs_pkg::ADDR_PRIO0 : drs_pkg::ADDR_PRIO1;
      // Loop 1 may take loop 2's VCO and the reverse
      localparam logic [2:0] OWN_LB = (gl == 0) ? drs_pkg::CODE_LOOP2_VCO
                                                : drs_pkg::CODE_LOOP1_VCO;

      logic [1:0] pin_s1;
      logic [1:0] pin_s2;
      logic [1:0] pin_s3;
      logic [1:0] pin_code;
      logic [drs_pkg::NUM_SLOTS-1:0] slot_ok;
      logic [3:0] best;
      logic [3:0] man;
      logic [2:0] man_code;
      drs_pkg::drs_mode_t mode;
      drs_pkg::drs_status_t next_stat;
      logic cur_ok;
      logic gap_any;
      logic switching;

      // Control and priority registers
      always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
          ctrl[gl] <= drs_pkg::CTRL_RESET;
        end else if (ce_i && reg_write_i && reg_addr_i == A_CTRL) begin
          ctrl[gl] <= reg_wdata_i[drs_pkg::CTRL_W-1:0];
        end
      end

      always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
          prio[gl] <= drs_pkg::PRIO_RESET;
        end else if (ce_i && reg_write_i && reg_addr_i == A_PRIO) begin
          prio[gl] <= reg_wdata_i[drs_pkg::NUM_SLOTS*drs_pkg::PRIO_W-1:0];
        end
      end

      // Select pins: three stages, accepted when the last two agree
      always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
          pin_s1 <= 2'b00;
          pin_s2 <= 2'b00;
          pin_s3 <= 2'b00;
          pin_code <= 2'b00;
        end else if (ce_i) begin
          pin_s1 <= input_select_pins_i[gl*2 +: 2];
          pin_s2 <= pin_s1;
          pin_s3 <= pin_s2;
          if (pin_s2 == pin_s3) begin
            pin_code <= pin_s3;
          end
        end
      end

      // Slot 4 is this loop's loopback; a slot only counts if it reaches
      // the common comparison rate
      assign slot_ok = {loopback_valid_i[gl], ext_valid}
                       & common_rate_ok_i[gl*drs_pkg::NUM_SLOTS +: drs_pkg::NUM_SLOTS];
      assign mode = drs_pkg::drs_mode_t'(ctrl[gl][drs_pkg::CTRL_MODE_LSB +: 2]);
      assign best = drs_best(slot_ok, prio[gl]);

      // Manual target as a slot; a foreign loopback code never qualifies
      always_comb begin
        man_code = ctrl[gl][drs_pkg::CTRL_CODE_LSB +: drs_pkg::CODE_W];
        man = 4'h0;
        if (ctrl[gl][drs_pkg::CTRL_PINS_BIT]) begin
          man = {slot_ok[pin_code], 1'b0, pin_code};
        end else if (man_code < 3'(drs_pkg::NUM_EXT)) begin
          man = {slot_ok[man_code[1:0]], man_code};
        end else if (man_code == OWN_LB) begin
          man = {slot_ok[drs_pkg::SLOT_LOOPBACK], drs_pkg::SLOT_LOOPBACK};
        end
      end

      // Current selection still usable for the non-revertive hold
      assign cur_ok = stat[gl].state == drs_pkg::DRS_ST_LOCKED
                      && slot_ok[stat[gl].sel == OWN_LB ? drs_pkg::SLOT_LOOPBACK
                                                        : {1'b0, stat[gl].sel[1:0]}];

      // Selection decision per mode
      always_comb begin
        next_stat.sel = stat[gl].sel;
        next_stat.state = history_valid_i[gl] ? drs_pkg::DRS_ST_HOLDOVER
                                              : drs_pkg::DRS_ST_FREERUN;
        unique case (mode)
          drs_pkg::DRS_AUTO_REVERT: begin
            if (best[3]) begin
              next_stat.sel = best[2:0];
              next_stat.state = drs_pkg::DRS_ST_LOCKED;
            end
          end
          drs_pkg::DRS_AUTO_HOLD: begin
            if (cur_ok) begin
              next_stat.state = drs_pkg::DRS_ST_LOCKED;
            end else if (best[3]) begin
              next_stat.sel = best[2:0];
              next_stat.state = drs_pkg::DRS_ST_LOCKED;
            end
          end
          drs_pkg::DRS_MAN_FALLBACK: begin
            if (man[3]) begin
              next_stat.sel = man[2:0];
              next_stat.state = drs_pkg::DRS_ST_LOCKED;
            end else if (best[3]) begin
              next_stat.sel = best[2:0];
              next_stat.state = drs_pkg::DRS_ST_LOCKED;
            end
          end
          drs_pkg::DRS_MAN_HOLDOVER: begin
            if (man[3]) begin
              next_stat.sel = man[2:0];
              next_stat.state = drs_pkg::DRS_ST_LOCKED;
            end
          end
        endcase
        // Loopback slot is reported by its own selection code
        if (next_stat.state == drs_pkg::DRS_ST_LOCKED
            && next_stat.sel == drs_pkg::SLOT_LOOPBACK) begin
          next_stat.sel = OWN_LB;
        end
      end

      // Loop status register, also driving the status pins
      always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
          stat[gl] <= '{state: drs_pkg::DRS_ST_FREERUN, sel: 3'h0};
        end else if (ce_i) begin
          stat[gl] <= next_stat;
        end
      end

      assign loop_status_o[gl] = stat[gl];

      // A switchover is a move from one locked input to another
      assign switching = stat[gl].state == drs_pkg::DRS_ST_LOCKED
                         && next_stat.state == drs_pkg::DRS_ST_LOCKED
                         && next_stat.sel != stat[gl].sel;
      // Gap on either end of a switch between external inputs
      assign gap_any = (stat[gl].sel < 3'(drs_pkg::NUM_EXT)
                        && input_in_gap_i[stat[gl].sel[1:0]])
                       || (next_stat.sel < 3'(drs_pkg::NUM_EXT)
                           && input_in_gap_i[next_stat.sel[1:0]]);

      // Switchover treatment: both ends already share the common rate here,
      // so they count as frequency-locked; the loop itself applies the
      // cancel, slew or smooth move. A one-cycle strobe per switch.
      always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
          switch_o[gl] <= '0;
        end else if (ce_i) begin
          switch_o[gl].phase_cancel <= switching
                                       && ctrl[gl][drs_pkg::CTRL_HITLESS_BIT]
                                       && !gap_any;
          switch_o[gl].phase_slew <= switching
                                     && !ctrl[gl][drs_pkg::CTRL_HITLESS_BIT];
          // Leaving holdover or freerun means no locked pair exists
          switch_o[gl].smooth_freq <= stat[gl].state != drs_pkg::DRS_ST_LOCKED
                                      && next_stat.state == drs_pkg::DRS_ST_LOCKED;
          switch_o[gl].gap_exempt <= switching && gap_any;
        end
      end
    end
  endgenerate

  // Read mux; unmapped addresses read zero
  always_comb begin
    next_rdata = 32'h0000_0000;
    unique case (reg_addr_i)
      drs_pkg::ADDR_CTRL0: next_rdata[drs_pkg::CTRL_W-1:0] = ctrl[0];
      drs_pkg::ADDR_CTRL1: next_rdata[drs_pkg::CTRL_W-1:0] = ctrl[1];
      drs_pkg::ADDR_PRIO0: next_rdata[drs_pkg::NUM_SLOTS*drs_pkg::PRIO_W-1:0] = prio[0];
      drs_pkg::ADDR_PRIO1: next_rdata[drs_pkg::NUM_SLOTS*drs_pkg::PRIO_W-1:0] = prio[1];
      drs_pkg::ADDR_VALTIME: next_rdata[VAL_W-1:0] = val_time;
      drs_pkg::ADDR_STAT0: begin
        next_rdata[drs_pkg::STAT_STATE_LSB +: 2] = stat[0].state;
        next_rdata[drs_pkg::STAT_SEL_LSB +: 3] = stat[0].sel;
        next_rdata[drs_pkg::STAT_VALID_LSB +: drs_pkg::NUM_EXT] = ext_valid;
      end
      drs_pkg::ADDR_STAT1: begin
        next_rdata[drs_pkg::STAT_STATE_LSB +: 2] = stat[1].state;
        next_rdata[drs_pkg::STAT_SEL_LSB +: 3] = stat[1].sel;
        next_rdata[drs_pkg::STAT_VALID_LSB +: drs_pkg::NUM_EXT] = ext_valid;
      end
      default: next_rdata = 32'h0000_0000;
    endcase
  end

  // Read data stand only in the cycle after the read strobe
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      reg_rdata_o <= 32'h0000_0000;
    end else if (ce_i) begin
      reg_rdata_o <= reg_read_i ? next_rdata : 32'h0000_0000;
    end
  end

endmodule : drs_selector

`default_nettype wire

// file: verif/drs_selector_sva.sv
`timescale 1ns/1ps
`default_nettype none
module drs_selector_sva #(
  parameter int VAL_W = drs_pkg::VAL_W
) (
  input wire logic clk_sys_i,
  input wire logic rstn_i,
  input wire logic ce_i,
  input wire logic [drs_pkg::ADDR_W-1:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_write_i,
  input wire logic reg_read_i,
  input wire logic [31:0] reg_rdata_o,
  input wire logic [drs_pkg::NUM_EXT-1:0] monitor_flag_i,
  input wire logic [drs_pkg::NUM_LOOPS-1:0] loopback_valid_i,
  input wire logic [drs_pkg::NUM_EXT-1:0] input_in_gap_i,
  input wire logic [drs_pkg::NUM_LOOPS*drs_pkg::NUM_SLOTS-1:0] common_rate_ok_i,
  input wire logic [drs_pkg::NUM_LOOPS-1:0] history_valid_i,
  input wire logic [drs_pkg::NUM_LOOPS*2-1:0] input_select_pins_i,
  input wire drs_pkg::drs_status_t [drs_pkg::NUM_LOOPS-1:0] loop_status_o,
  input wire drs_pkg::drs_switch_t [drs_pkg::NUM_LOOPS-1:0] switch_o,
  input wire logic [drs_pkg::NUM_EXT-1:0] input_valid_o
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rstn_i);
  logic [3:0] prev_valid;
  // Status lags validity by one cycle, so it is judged against last cycle
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) prev_valid <= 4'h0;
    else prev_valid <= input_valid_o;
  end
  // Input 0 leaves its flagged state and stays clear long enough to qualify
  sequence s_clear_start;
    $fell(monitor_flag_i[0]);
  endsequence
  sequence s_clear_long;
    s_clear_start ##1 (!monitor_flag_i[0]) [*8] ##1 (!monitor_flag_i[0]) [*8]
      ##1 !monitor_flag_i[0];
  endsequence
  a_rdata_idle_zero: assert property (!$past(reg_read_i) |-> reg_rdata_o == 32'h0000_0000)
    else $error("read data not zero outside a read answer");
  a_valid_not_early: assert property (s_clear_start |-> (!input_valid_o[0]) [*8])
    else $error("input qualified before its validation time");
  a_valid_in_time: assert property (s_clear_long |-> ##[0:3] input_valid_o[0])
    else $error("clear input never qualified");
  a_flag_drops_valid: assert property ((input_valid_o & $past(monitor_flag_i)) == 4'h0)
    else $error("flagged input still shown valid");
  a_locked_on_valid: assert property (loop_status_o[0].state == drs_pkg::DRS_ST_LOCKED
    && loop_status_o[0].sel < 3'h4 |-> prev_valid[loop_status_o[0].sel[1:0]])
    else $error("loop locked on an invalid input");
  a_own_vco_never: assert property (loop_status_o[0].sel != drs_pkg::CODE_LOOP1_VCO
    && loop_status_o[1].sel != drs_pkg::CODE_LOOP2_VCO)
    else $error("loop selected its own loopback");
  a_holdover_history: assert property ($rose(loop_status_o[0].state == drs_pkg::DRS_ST_HOLDOVER)
    |-> $past(history_valid_i[0]))
    else $error("holdover entered without history");
  a_freerun_history: assert property ($rose(loop_status_o[0].state == drs_pkg::DRS_ST_FREERUN)
    |-> !$past(history_valid_i[0]))
    else $error("free-run entered with valid history");
  a_strobe_single: assert property (switch_o[0].smooth_freq |=> !switch_o[0].smooth_freq)
    else $error("smooth strobe longer than one cycle");
  a_cancel_excl: assert property (!(switch_o[0].phase_cancel
    && (switch_o[0].phase_slew || switch_o[0].gap_exempt)))
    else $error("phase cancel beside slew or gap");
endmodule : drs_selector_sva
bind drs_selector drs_selector_sva #(.VAL_W(VAL_W)) drs_selector_sva_inst (.*);
`default_nettype wire

// file: verif/drs_ref_src_model.sv
`timescale 1ns/1ps
`default_nettype none
module drs_ref_src_model (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic [3:0] good_i,
  output logic [3:0] flag_o,
  output logic [3:0] gap_o
);
  logic [2:0] phase;
  // Monitors flag only a dead source; gapping alone never raises a flag
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      flag_o <= 4'hF;
      phase <= 3'h0;
    end else begin
      flag_o <= ~good_i;
      phase <= phase + 3'h1;
    end
  end
  // One missing period in eight, shorter than a divided period
  assign gap_o = (phase == 3'h7) ? good_i : 4'h0;
endmodule : drs_ref_src_model
`default_nettype wire

// file: verif/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
  localparam drs_pkg::drs_state_t LOCK = drs_pkg::DRS_ST_LOCKED;
  localparam drs_pkg::drs_state_t HOLD = drs_pkg::DRS_ST_HOLDOVER;
  localparam drs_pkg::drs_state_t FREE = drs_pkg::DRS_ST_FREERUN;
  logic clk_sys_i = 1'b0;
  logic rstn_i = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [3:0] good = 4'h0;
  logic [1:0] lb_ok = 2'h0;
  logic [1:0] hist = 2'h0;
  logic [3:0] pins = 4'h0;
  logic [31:0] rdata;
  logic [3:0] flag;
  logic [3:0] gap;
  drs_pkg::drs_status_t [1:0] st;
  drs_pkg::drs_switch_t [1:0] sw;
  logic [7:0] sw_seen = 8'h00;
  logic sw_clr = 1'b0;
  logic [9:0] rate_ok = 10'h3FF;
  int n_fail = 0;
  int cmp_count = 0;
  always #12.5 clk_sys_i = ~clk_sys_i;
  // Every loop may reach every slot at the common rate
  drs_selector drs_selector_inst (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .ce_i(1'b1),
    .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_write_i(wr), .reg_read_i(rd),
    .reg_rdata_o(rdata), .monitor_flag_i(flag), .loopback_valid_i(lb_ok),
    .input_in_gap_i(gap), .common_rate_ok_i(rate_ok), .history_valid_i(hist),
    .input_select_pins_i(pins), .loop_status_o(st), .switch_o(sw), .input_valid_o());
  // Sticky record of switchover strobes since the last source change
  always @(posedge clk_sys_i) begin
    if (sw_clr) begin
      sw_seen <= 8'h00;
    end else begin
      sw_seen <= sw_seen | sw;
    end
  end
  drs_ref_src_model drs_ref_src_model_inst (.clk_i(clk_sys_i), .rstn_i(rstn_i),
    .good_i(good), .flag_o(flag), .gap_o(gap));
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %0t mismatch got %h exp %h", $time, got, exp);
    end
  endtask : check
  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys_i);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk_sys_i);
    wr <= 1'b0;
  endtask : reg_wr
  // Read data stand only in the cycle after the strobe
  task automatic reg_chk(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk_sys_i);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk_sys_i);
    rd <= 1'b0;
    #1;
    check(rdata, e);
  endtask : reg_chk
  // Validation takes a few tens of cycles, so the wait is bounded at 80
  task automatic expect_st(input int l, input drs_pkg::drs_state_t t, input logic [2:0] s);
    for (int i = 0; i < 80 && st[l] !== {t, s}; i++) begin
      @(posedge clk_sys_i);
      #1;
    end
    check({27'h000_0000, st[l]}, {27'h000_0000, t, s});
  endtask : expect_st
  task automatic src(input logic [3:0] g, input logic [1:0] h);
    @(posedge clk_sys_i);
    good <= g;
    hist <= h;
    sw_clr <= 1'b1;
    @(posedge clk_sys_i);
    sw_clr <= 1'b0;
  endtask : src
  task automatic t_reset;
    reg_chk(drs_pkg::ADDR_CTRL0, 32'h0000_0000);
    reg_chk(drs_pkg::ADDR_PRIO1, 32'h0000_0000);
    reg_chk(drs_pkg::ADDR_VALTIME, 32'h0000_0010);
    reg_chk(drs_pkg::ADDR_STAT0, 32'h0000_0000);
    reg_wr(8'h40, 32'hFFFF_FFFF);
    reg_chk(8'h40, 32'h0000_0000);
  endtask : t_reset
  // Priorities 3,2,2,0,0 give a tie and an ignored input
  task automatic t_revert;
    reg_wr(drs_pkg::ADDR_PRIO0, 32'h0000_0093);
    reg_wr(drs_pkg::ADDR_CTRL0, 32'h0000_0040);
    src(4'b1101, 2'b11);
    expect_st(0, LOCK, 3'h2);
    reg_chk(drs_pkg::ADDR_STAT0, 32'h0000_01AA);
    src(4'b1111, 2'b11);
    expect_st(0, LOCK, 3'h1);
    @(posedge clk_sys_i);
    #1;
    check({30'h0000_0000, sw_seen[3] | sw_seen[0], sw_seen[2]}, 32'h0000_0002);
    src(4'b1000, 2'b11);
    expect_st(0, HOLD, 3'h1);
  endtask : t_revert
  task automatic t_nonrev;
    reg_wr(drs_pkg::ADDR_PRIO1, 32'h0000_0093);
    reg_wr(drs_pkg::ADDR_CTRL1, 32'h0000_0001);
    src(4'b0001, 2'b11);
    expect_st(1, LOCK, 3'h0);
    src(4'b0111, 2'b11);
    repeat (40) @(posedge clk_sys_i);
    expect_st(1, LOCK, 3'h0);
    src(4'b0110, 2'b11);
    expect_st(1, LOCK, 3'h1);
    @(posedge clk_sys_i);
    #1;
    check({31'h0000_0000, sw_seen[6]}, 32'h0000_0001);
  endtask : t_nonrev
  // Manual input 3 by register, then loss with and without fallback
  task automatic t_manual;
    reg_wr(drs_pkg::ADDR_CTRL0, 32'h0000_001B);
    src(4'b1000, 2'b11);
    expect_st(0, LOCK, 3'h3);
    src(4'b0111, 2'b11);
    expect_st(0, HOLD, 3'h3);
    src(4'b1111, 2'b11);
    expect_st(0, LOCK, 3'h3);
    @(posedge clk_sys_i);
    #1;
    check({31'h0000_0000, sw_seen[1]}, 32'h0000_0001);
    reg_wr(drs_pkg::ADDR_CTRL0, 32'h0000_001A);
    src(4'b0111, 2'b11);
    expect_st(0, LOCK, 3'h1);
    src(4'b0000, 2'b10);
    expect_st(0, FREE, 3'h1);
  endtask : t_manual
  task automatic t_codes;
    @(posedge clk_sys_i);
    lb_ok <= 2'b11;
    src(4'b1111, 2'b11);
    reg_wr(drs_pkg::ADDR_CTRL0, 32'h0000_002B);
    expect_st(0, LOCK, 3'h5);
    reg_wr(drs_pkg::ADDR_CTRL1, 32'h0000_0023);
    expect_st(1, LOCK, 3'h4);
    for (int c = 0; c < 4; c++) begin
      reg_wr(drs_pkg::ADDR_CTRL0, {26'h000_0000, c[2:0], 3'h3});
      expect_st(0, LOCK, c[2:0]);
    end
    reg_chk(drs_pkg::ADDR_STAT1, 32'h0000_01EC);
    reg_wr(drs_pkg::ADDR_CTRL0, 32'h0000_0007);
    for (int p = 0; p < 4; p++) begin
      @(posedge clk_sys_i);
      pins <= {2'b00, p[1:0]};
      expect_st(0, LOCK, p[2:0]);
    end
    // Input 3 loses the common rate for loop 0, so the manual pick drops
    @(posedge clk_sys_i);
    rate_ok <= 10'h3F7;
    expect_st(0, HOLD, 3'h3);
  endtask : t_codes
  task automatic final_report;
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : final_report
  // Main sequence after an eight-cycle reset
  initial begin
    repeat (8) @(posedge clk_sys_i);
    rstn_i <= 1'b1;
    t_reset();
    t_revert();
    t_nonrev();
    t_manual();
    t_codes();
    final_report();
  end
  // The run needs a few hundred cycles; a hang is cut at 20000, far beyond that
  initial begin
    repeat (20000) @(posedge clk_sys_i);
    n_fail++;
    final_report();
  end
endmodule : tb
`default_nettype wire
